// ### design/cowr_pkg.sv
package cowr_pkg;
  // Register addresses (5-bit configuration register numbers)
  localparam logic [4:0] ADDR_ID_CHECK = 5'h0c;
  localparam logic [4:0] ADDR_USER_WORD = 5'h0d;
  localparam logic [4:0] ADDR_OPTIONS_ONE = 5'h0e;
  localparam logic [4:0] ADDR_WARM_BOOT = 5'h10;
  localparam logic [4:0] ADDR_WATCHDOG = 5'h11;
  // Frame data input register number, gated by the identification check
  localparam logic [4:0] ADDR_FRAME_DATA = 5'h02;

  // Reset values
  localparam logic [31:0] RST_OPTIONS_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_WARM_BOOT = 32'h0000_0000;
  localparam logic [31:0] RST_WATCHDOG = 32'h0000_0000;
  localparam logic [31:0] RST_USER_WORD = 32'h0000_0000;

  // Options-one fields
  localparam int OPT_KEEP_RELEASE_BIT = 17;
  localparam int OPT_CHECK_ACTION_HI = 16;
  localparam int OPT_CHECK_ACTION_LO = 15;
  localparam int OPT_ERR_PIN_OFF_BIT = 9;
  localparam int OPT_CHECK_ON_BIT = 8;
  localparam int OPT_FIRST_READ_HI = 3;
  localparam int OPT_FIRST_READ_LO = 2;
  localparam int OPT_PAGE_HI = 1;
  localparam int OPT_PAGE_LO = 0;
  localparam logic [31:0] OPT_WRITE_MASK = 32'h0003_830f;

  // Warm-boot fields
  localparam int WB_REV_HI = 31;
  localparam int WB_REV_LO = 30;
  localparam int WB_DRIVE_ON_BIT = 29;
  localparam int WB_ADDR_HI = 28;

  // Watchdog fields
  localparam int WD_USER_ON_BIT = 31;
  localparam int WD_LOAD_ON_BIT = 30;
  localparam int WD_COUNT_HI = 29;

  // Readback check action encodings
  typedef enum logic [1:0] {
    ACT_CONTINUE = 2'b00,
    ACT_HALT = 2'b01,
    ACT_CORRECT_CONTINUE = 2'b10,
    ACT_CORRECT_HALT = 2'b11
  } cowr_action_t;

  // Page length encodings
  localparam logic [1:0] PAGE_ONE = 2'b00;
  localparam logic [1:0] PAGE_FOUR = 2'b01;
  localparam logic [1:0] PAGE_EIGHT = 2'b10;
  localparam logic [1:0] PAGE_RESERVED = 2'b11;
endpackage : cowr_pkg

// ### design/cowr_watchdog.sv
`timescale 1ns/10ps
module cowr_watchdog #(
  parameter int CNT_W = 30
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Slow tick, already synchronised
  input wire logic tick_i,
  // Control
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [CNT_W-1:0] limit_i,
  // Expiry pulse
  output logic expire_o
);
  logic [CNT_W-1:0] cnt_d, cnt_q;
  logic expire_d, expire_q;

  always_comb begin
    cnt_d = cnt_q;
    expire_d = 1'b0;
    if (!run_i || restart_i) begin
      cnt_d = '0;
    end else if (tick_i) begin
      if (cnt_q >= limit_i) begin
        expire_d = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expire_q <= expire_d;
    end
  end

  assign expire_o = expire_q;
endmodule : cowr_watchdog

// ### design/cowr_regs.sv
`timescale 1ns/10ps
module cowr_regs #(
  parameter logic [31:0] DEVICE_CODE = 32'h1234_5678, // Arbitrary value
  parameter int ADDR_W = 29,
  parameter int WD_W = 30
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Configuration register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Frame data gate
  output logic frame_wr_o,
  output logic [31:0] frame_data_o,
  output logic ident_error_o,
  // Fabric user word
  output logic [31:0] fabric_user_word_port_o,
  // Commands and phases
  input wire logic internal_reprogram_cmd_i,
  input wire logic unsync_command_i,
  input wire logic fallback_i,
  input wire logic user_mode_i,
  input wire logic loading_i,
  // Watchdog slow clock (asynchronous)
  input wire logic wd_clk_i,
  // Retained pins
  output logic config_pins_retained_o,
  // Readback check controls
  input wire logic readback_crc_err_i,
  output logic readback_check_on_o,
  output logic readback_halt_o,
  output logic readback_correct_o,
  output logic init_err_o,
  output logic init_err_oe_o,
  // Flash read controls
  output logic [2:0] flash_first_read_delay_o,
  output logic [3:0] flash_page_length_o,
  // Reboot
  output logic reboot_o,
  output logic [ADDR_W-1:0] reboot_addr_o,
  output logic fallback_start_o,
  output logic watchdog_timeout_o,
  // Revision select pins
  output logic [1:0] revision_select_pins_o,
  output logic revision_select_pins_oe_o
);
  logic [31:0] user_d, user_q;
  logic [31:0] opt_d, opt_q;
  logic [31:0] wb_d, wb_q;
  logic [31:0] wd_d, wd_q;
  logic id_ok_d, id_ok_q;
  logic id_err_d, id_err_q;
  logic [31:0] rdata_d, rdata_q;
  logic rvalid_d, rvalid_q;
  logic frame_wr_d, frame_wr_q;
  logic [31:0] frame_data_d, frame_data_q;
  logic retained_d, retained_q;
  logic fallback_drv_d, fallback_drv_q;
  logic [1:0] rev_d, rev_q;
  logic rev_oe_d, rev_oe_q;
  logic reboot_d, reboot_q;
  logic [ADDR_W-1:0] reboot_addr_d, reboot_addr_q;
  logic fb_start_d, fb_start_q;
  logic wd_err_d, wd_err_q;
  logic halt_d, halt_q;
  logic [2:0] wd_sync_d, wd_sync_q;
  logic wd_level_d, wd_level_q;
  logic init_err_d, init_err_q;
  logic wd_tick;
  logic wd_run;
  logic wd_restart;
  logic wd_expire;
  logic wr_id, wr_frame;

  assign wr_id = reg_wr_i && (reg_addr_i == cowr_pkg::ADDR_ID_CHECK);
  assign wr_frame = reg_wr_i && (reg_addr_i == cowr_pkg::ADDR_FRAME_DATA);

  // Slow clock sampled by three flops; edge counts when stages two and three agree
  always_comb begin
    wd_sync_d = {wd_sync_q[1:0], wd_clk_i};
    wd_level_d = wd_level_q;
    if (wd_sync_q[1] == wd_sync_q[2]) begin
      wd_level_d = wd_sync_q[2];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wd_sync_q <= 3'h0;
      wd_level_q <= 1'b0;
    end else begin
      wd_sync_q <= wd_sync_d;
      wd_level_q <= wd_level_d;
    end
  end

  // Tick only on a settled low-to-high change of the slow clock
  assign wd_tick = (wd_sync_q[1] == wd_sync_q[2]) && wd_sync_q[2] && !wd_level_q;

  // Monitor only in enabled phases, never for fallback images
  assign wd_run = !fallback_i && (
    (user_mode_i && wd_q[cowr_pkg::WD_USER_ON_BIT]) ||
    (loading_i && wd_q[cowr_pkg::WD_LOAD_ON_BIT]));
  // Any write to the watchdog register restarts the count
  assign wd_restart = reg_wr_i && (reg_addr_i == cowr_pkg::ADDR_WATCHDOG);

  cowr_watchdog #(
    .CNT_W(WD_W)
  ) u_watchdog (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(wd_tick),
    .run_i(wd_run),
    .restart_i(wd_restart),
    .limit_i(wd_q[WD_W-1:0]),
    .expire_o(wd_expire)
  );

  // Register writes
  always_comb begin
    user_d = user_q;
    opt_d = opt_q;
    wb_d = wb_q;
    wd_d = wd_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        cowr_pkg::ADDR_USER_WORD: user_d = reg_wdata_i;
        // Unimplemented option bits stay zero
        cowr_pkg::ADDR_OPTIONS_ONE: opt_d = reg_wdata_i & cowr_pkg::OPT_WRITE_MASK;
        cowr_pkg::ADDR_WARM_BOOT: wb_d = reg_wdata_i;
        cowr_pkg::ADDR_WATCHDOG: wd_d = reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      user_q <= cowr_pkg::RST_USER_WORD;
      opt_q <= cowr_pkg::RST_OPTIONS_ONE;
      wb_q <= cowr_pkg::RST_WARM_BOOT;
      wd_q <= cowr_pkg::RST_WATCHDOG;
    end else begin
      user_q <= user_d;
      opt_q <= opt_d;
      wb_q <= wb_d;
      wd_q <= wd_d;
    end
  end

  // Identification check and frame data gate
  always_comb begin
    id_ok_d = id_ok_q;
    id_err_d = id_err_q;
    frame_wr_d = 1'b0;
    frame_data_d = frame_data_q;
    if (wr_id) begin
      id_ok_d = (reg_wdata_i == DEVICE_CODE);
      // Sticky: a later good code cannot reopen the gate
      id_err_d = id_err_q || (reg_wdata_i != DEVICE_CODE);
    end
    // Frame words pass only after a matching check
    if (wr_frame && id_ok_q && !id_err_q) begin
      frame_wr_d = 1'b1;
      frame_data_d = reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      id_ok_q <= 1'b0;
      id_err_q <= 1'b0;
      frame_wr_q <= 1'b0;
      frame_data_q <= 32'h0000_0000;
    end else begin
      id_ok_q <= id_ok_d;
      id_err_q <= id_err_d;
      frame_wr_q <= frame_wr_d;
      frame_data_q <= frame_data_d;
    end
  end

  // Read path
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        cowr_pkg::ADDR_ID_CHECK: rdata_d = DEVICE_CODE;
        cowr_pkg::ADDR_USER_WORD: rdata_d = user_q;
        cowr_pkg::ADDR_OPTIONS_ONE: rdata_d = opt_q;
        cowr_pkg::ADDR_WARM_BOOT: rdata_d = wb_q;
        cowr_pkg::ADDR_WATCHDOG: rdata_d = wd_q;
        // Unmapped numbers read as zero
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Retained pins and readback error reporting
  always_comb begin
    retained_d = retained_q;
    halt_d = halt_q;
    if (unsync_command_i && opt_q[cowr_pkg::OPT_KEEP_RELEASE_BIT]) begin
      retained_d = 1'b0;
    end
    // Halt flag keeps the error report after the error input drops
    if (readback_crc_err_i && opt_q[cowr_pkg::OPT_CHECK_ON_BIT] && readback_halt_o) begin
      halt_d = 1'b1;
    end
    init_err_d = halt_q || (readback_crc_err_i && opt_q[cowr_pkg::OPT_CHECK_ON_BIT]);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      retained_q <= 1'b1;
      halt_q <= 1'b0;
      init_err_q <= 1'b0;
    end else begin
      retained_q <= retained_d;
      halt_q <= halt_d;
      init_err_q <= init_err_d;
    end
  end

  // Reboot, revision select and watchdog events
  always_comb begin
    fallback_drv_d = fallback_drv_q;
    reboot_d = 1'b0;
    reboot_addr_d = reboot_addr_q;
    fb_start_d = 1'b0;
    wd_err_d = wd_err_q;
    rev_d = rev_q;
    rev_oe_d = rev_oe_q;
    if (internal_reprogram_cmd_i) begin
      reboot_d = 1'b1;
      reboot_addr_d = wb_q[cowr_pkg::WB_ADDR_HI:0];
      rev_d = wb_q[cowr_pkg::WB_REV_HI:cowr_pkg::WB_REV_LO];
      rev_oe_d = wb_q[cowr_pkg::WB_DRIVE_ON_BIT];
      fallback_drv_d = 1'b0;
    end
    // Expiry comes last so it wins over a reprogram in the same cycle
    if (wd_expire) begin
      wd_err_d = 1'b1;
      fb_start_d = 1'b1;
      reboot_d = 1'b1;
      reboot_addr_d = '0;
      fallback_drv_d = 1'b1;
    end
    if (fallback_drv_d) begin
      rev_d = 2'b00;
      rev_oe_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fallback_drv_q <= 1'b0;
      rev_q <= 2'b00;
      rev_oe_q <= 1'b0;
      reboot_q <= 1'b0;
      reboot_addr_q <= '0;
      fb_start_q <= 1'b0;
      wd_err_q <= 1'b0;
    end else begin
      fallback_drv_q <= fallback_drv_d;
      rev_q <= rev_d;
      rev_oe_q <= rev_oe_d;
      reboot_q <= reboot_d;
      reboot_addr_q <= reboot_addr_d;
      fb_start_q <= fb_start_d;
      wd_err_q <= wd_err_d;
    end
  end

  // Option decodes
  logic [1:0] action;
  logic [1:0] page;
  assign action = opt_q[cowr_pkg::OPT_CHECK_ACTION_HI:cowr_pkg::OPT_CHECK_ACTION_LO];
  assign page = opt_q[cowr_pkg::OPT_PAGE_HI:cowr_pkg::OPT_PAGE_LO];

  assign readback_check_on_o = opt_q[cowr_pkg::OPT_CHECK_ON_BIT];
  assign readback_halt_o = (action == cowr_pkg::ACT_HALT) || (action == cowr_pkg::ACT_CORRECT_HALT);
  assign readback_correct_o = action[1];
  assign init_err_o = init_err_q;
  assign init_err_oe_o = !opt_q[cowr_pkg::OPT_ERR_PIN_OFF_BIT];
  assign flash_first_read_delay_o = {1'b0, opt_q[cowr_pkg::OPT_FIRST_READ_HI:cowr_pkg::OPT_FIRST_READ_LO]}
    + 3'h1;
  // Reserved page code falls back to single reads
  assign flash_page_length_o = (page == cowr_pkg::PAGE_FOUR) ? 4'h4 :
    (page == cowr_pkg::PAGE_EIGHT) ? 4'h8 : 4'h1;

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign frame_wr_o = frame_wr_q;
  assign frame_data_o = frame_data_q;
  assign ident_error_o = id_err_q;
  assign fabric_user_word_port_o = user_q;
  assign config_pins_retained_o = retained_q;
  assign reboot_o = reboot_q;
  assign reboot_addr_o = reboot_addr_q;
  assign fallback_start_o = fb_start_q;
  assign watchdog_timeout_o = wd_err_q;
  assign revision_select_pins_o = rev_q;
  assign revision_select_pins_oe_o = rev_oe_q;
endmodule : cowr_regs

// ### verif/cowr_regs_props.sv
`timescale 1ns/10ps
module cowr_regs_chk #(
  parameter logic [31:0] DEVICE_CODE = 32'h1234_5678
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  // Frame gate and user word
  input wire logic frame_wr_o,
  input wire logic [31:0] frame_data_o,
  input wire logic ident_error_o,
  input wire logic [31:0] fabric_user_word_port_o,
  // Reboot
  input wire logic internal_reprogram_cmd_i,
  input wire logic fallback_i,
  input wire logic reboot_o,
  input wire logic fallback_start_o,
  input wire logic watchdog_timeout_o,
  input wire logic [1:0] revision_select_pins_o,
  input wire logic revision_select_pins_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_id_readback: assert property (reg_rd_i && reg_addr_i == 5'h0c |=> reg_rdata_o == DEVICE_CODE)
    else $error("id read wrong");
  a_id_mismatch: assert property (reg_wr_i && reg_addr_i == 5'h0c && reg_wdata_i != DEVICE_CODE |=> ident_error_o)
    else $error("id mismatch not flagged");
  a_frame_source: assert property (frame_wr_o |-> $past(reg_wr_i) && $past(reg_addr_i) == 5'h02
    && frame_data_o == $past(reg_wdata_i)) else $error("frame write without request");
  a_user_word: assert property (reg_wr_i && reg_addr_i == 5'h0d |=> fabric_user_word_port_o == $past(reg_wdata_i))
    else $error("user word not shown");
  a_reprogram_boot: assert property (internal_reprogram_cmd_i |=> reboot_o)
    else $error("reprogram without reboot");
  a_fallback_pins: assert property (fallback_start_o |-> revision_select_pins_o == 2'b00 && revision_select_pins_oe_o)
    else $error("fallback pins not driven low");
  a_timeout_sticky: assert property (watchdog_timeout_o |=> watchdog_timeout_o)
    else $error("timeout flag lost");
  a_fallback_quiet: assert property (fallback_i [*4] |-> !fallback_start_o)
    else $error("watchdog fired in fallback");
endmodule : cowr_regs_chk

bind cowr_regs cowr_regs_chk #(.DEVICE_CODE(DEVICE_CODE)) u_chk (.ref_clk_i, .rst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .frame_wr_o, .frame_data_o, .ident_error_o, .fabric_user_word_port_o,
  .internal_reprogram_cmd_i, .fallback_i, .reboot_o, .fallback_start_o, .watchdog_timeout_o,
  .revision_select_pins_o, .revision_select_pins_oe_o);

// ### verif/cowr_src.sv
`timescale 1ns/10ps
module cowr_src #(
  parameter logic [31:0] CODE = 32'h0
) (
  // Clock
  input wire logic ref_clk_i,
  // Register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [4:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  // Read answer
  input wire logic [31:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 5'h00;
    reg_wdata_o = 32'h0;
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    // Released lines do not keep the last value
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rvalid_i ? reg_rdata_i : 32'hxxxx_xxxx;
  endtask : rd
  task automatic frame_load(input logic [31:0] d);
    wr(cowr_pkg::ADDR_ID_CHECK, CODE);
    wr(cowr_pkg::ADDR_FRAME_DATA, d);
  endtask : frame_load
endmodule : cowr_src

// ### verif/tb_config_option_watchdog_regs.sv
`timescale 1ns/10ps
module tb_config_option_watchdog_regs;
  localparam logic [31:0] CODE = 32'h0bad_c0de; // Arbitrary value
  logic ref_clk_i, rst_i, internal_reprogram_cmd_i, unsync_command_i, fallback_i, user_mode_i, loading_i;
  logic readback_crc_err_i, reg_wr_i, reg_rd_i, reg_rvalid_o, frame_wr_o, ident_error_o, config_pins_retained_o;
  logic readback_check_on_o, readback_halt_o, readback_correct_o, init_err_o, init_err_oe_o, reboot_o;
  logic fallback_start_o, watchdog_timeout_o, revision_select_pins_oe_o, wd_clk_i;
  logic [4:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, frame_data_o, fabric_user_word_port_o, d;
  logic [2:0] flash_first_read_delay_o;
  logic [3:0] flash_page_length_o, wd_div;
  logic [28:0] reboot_addr_o;
  logic [1:0] revision_select_pins_o;
  int bad_count, n_compared;
  assign wd_clk_i = wd_div[3];
  cowr_regs #(.DEVICE_CODE(CODE)) u_dut (.ref_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .frame_wr_o, .frame_data_o, .ident_error_o, .fabric_user_word_port_o,
    .internal_reprogram_cmd_i, .unsync_command_i, .fallback_i, .user_mode_i, .loading_i, .wd_clk_i,
    .config_pins_retained_o, .readback_crc_err_i, .readback_check_on_o, .readback_halt_o, .readback_correct_o,
    .init_err_o, .init_err_oe_o, .flash_first_read_delay_o, .flash_page_length_o, .reboot_o, .reboot_addr_o,
    .fallback_start_o, .watchdog_timeout_o, .revision_select_pins_o, .revision_select_pins_oe_o);
  cowr_src #(.CODE(CODE)) u_src (.ref_clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) wd_div <= wd_div + 4'h1;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic wait_fb(input int lim, output logic seen);
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      @(posedge ref_clk_i);
      #1;
      seen = (fallback_start_o === 1'b1);
    end
  endtask : wait_fb
  task automatic t_frame();
    u_src.rd(cowr_pkg::ADDR_OPTIONS_ONE, d);
    chk("opt reset", d, 32'h0);
    chk("retained", config_pins_retained_o, 1);
    u_src.wr(cowr_pkg::ADDR_FRAME_DATA, 32'h1111_2222);
    chk("frame early", frame_wr_o, 0);
    u_src.frame_load(32'h3333_4444);
    chk("frame wr", frame_wr_o, 1);
    chk("frame data", frame_data_o, 32'h3333_4444);
    u_src.wr(cowr_pkg::ADDR_ID_CHECK, ~CODE);
    chk("id err", ident_error_o, 1);
    u_src.wr(cowr_pkg::ADDR_FRAME_DATA, 32'h5555_6666);
    chk("frame refused", frame_wr_o, 0);
    u_src.rd(cowr_pkg::ADDR_ID_CHECK, d);
    chk("id read", d, CODE);
    $display("frame test done");
  endtask : t_frame
  task automatic t_options();
    logic [3:0] pg[4];
    pg = '{4'h1, 4'h4, 4'h8, 4'h1};
    u_src.wr(cowr_pkg::ADDR_OPTIONS_ONE, 32'hffff_ffff);
    u_src.rd(cowr_pkg::ADDR_OPTIONS_ONE, d);
    chk("opt mask", d, 32'h0003_830f);
    chk("check on", readback_check_on_o, 1);
    chk("pin off", init_err_oe_o, 0);
    @(posedge ref_clk_i) readback_crc_err_i <= 1'b1;
    @(posedge ref_clk_i) readback_crc_err_i <= 1'b0;
    #1;
    chk("halted", init_err_o, 1);
    @(posedge ref_clk_i) unsync_command_i <= 1'b1;
    @(posedge ref_clk_i) unsync_command_i <= 1'b0;
    #1;
    chk("released", config_pins_retained_o, 0);
    for (int i = 0; i < 4; i++) begin
      u_src.wr(cowr_pkg::ADDR_OPTIONS_ONE, {15'h0, i[1:0], 11'h0, i[1:0], i[1:0]});
      chk("first read", flash_first_read_delay_o, i + 1);
      chk("page", flash_page_length_o, pg[i]);
      chk("halt", readback_halt_o, i[0]);
      chk("correct", readback_correct_o, i[1]);
    end
    chk("pin on", init_err_oe_o, 1);
    $display("options test done");
  endtask : t_options
  task automatic t_boot();
    u_src.wr(cowr_pkg::ADDR_USER_WORD, 32'ha5c3_0f96);
    chk("user word", fabric_user_word_port_o, 32'ha5c3_0f96);
    u_src.wr(cowr_pkg::ADDR_WARM_BOOT, {2'b10, 1'b1, 29'h0abc_def});
    chk("rev oe idle", revision_select_pins_oe_o, 0);
    @(posedge ref_clk_i) internal_reprogram_cmd_i <= 1'b1;
    @(posedge ref_clk_i) internal_reprogram_cmd_i <= 1'b0;
    #1;
    chk("reboot", reboot_o, 1);
    chk("addr", reboot_addr_o, 29'h0abc_def);
    chk("rev", revision_select_pins_o, 2'b10);
    chk("rev oe", revision_select_pins_oe_o, 1);
    $display("boot test done");
  endtask : t_boot
  task automatic t_watchdog();
    logic seen;
    @(posedge ref_clk_i) fallback_i <= 1'b1;
    user_mode_i <= 1'b1;
    u_src.wr(cowr_pkg::ADDR_WATCHDOG, {1'b1, 1'b0, 30'h2});
    wait_fb(300, seen);
    chk("quiet", seen, 0);
    chk("quiet flag", watchdog_timeout_o, 0);
    @(posedge ref_clk_i) fallback_i <= 1'b0;
    wait_fb(2000, seen);
    chk("user expiry", seen, 1);
    if (!seen) conclude();
    chk("timeout", watchdog_timeout_o, 1);
    chk("fb reboot", reboot_o, 1);
    chk("fb addr", reboot_addr_o, 29'h0);
    chk("fb rev", revision_select_pins_o, 2'b00);
    chk("fb oe", revision_select_pins_oe_o, 1);
    u_src.wr(cowr_pkg::ADDR_WATCHDOG, {1'b0, 1'b1, 30'h1});
    wait_fb(300, seen);
    chk("user off", seen, 0);
    @(posedge ref_clk_i) user_mode_i <= 1'b0;
    loading_i <= 1'b1;
    wait_fb(2000, seen);
    chk("load expiry", seen, 1);
    if (!seen) conclude();
    chk("load fb rev", revision_select_pins_o, 2'b00);
    @(posedge ref_clk_i) loading_i <= 1'b0;
    $display("watchdog test done");
  endtask : t_watchdog
  task automatic t_reset();
    @(posedge ref_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rst id err", ident_error_o, 0);
    chk("rst timeout", watchdog_timeout_o, 0);
    chk("rst retained", config_pins_retained_o, 1);
    chk("rst rev oe", revision_select_pins_oe_o, 0);
    chk("rst init err", init_err_o, 0);
    u_src.rd(cowr_pkg::ADDR_WARM_BOOT, d);
    chk("rst boot", d, 32'h0);
    u_src.frame_load(32'h7777_8888);
    chk("gate reopen", frame_wr_o, 1);
    chk("reopen data", frame_data_o, 32'h7777_8888);
    $display("reset test done");
  endtask : t_reset
  initial begin
    {rst_i, internal_reprogram_cmd_i, unsync_command_i, fallback_i} = 4'h8;
    {user_mode_i, loading_i, readback_crc_err_i} = 3'h0;
    wd_div = 4'h0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_frame();
    t_options();
    t_boot();
    t_watchdog();
    t_reset();
    conclude();
  end
endmodule : tb_config_option_watchdog_regs
